// ===== common/can_filt_map.vh
// can_filt_map.vh: offsets, field positions, reset values and limits
// assumes an 8-bit apb byte address; every register holds at most 8 bits, in the low byte of one 32-bit word
`ifndef CAN_FILT_MAP_VH
`define CAN_FILT_MAP_VH

// register byte addresses
`define ADR_CTRL0 8'h00
`define ADR_CTRL1 8'h04
`define ADR_BT0 8'h08
`define ADR_BT1 8'h0C
`define ADR_RFLG 8'h10
`define ADR_RIER 8'h14
`define ADR_TFLG 8'h18
`define ADR_TIER 8'h1C
`define ADR_IDAC 8'h20
`define ADR_RXERR 8'h24
`define ADR_TXERR 8'h28
// 0x40..0x5c pattern bytes 0..7, 0x60..0x7c mask bytes 0..7
`define FILT_PAGE 2'b01

// module_control_0 fields
`define C0_SOFT 0
`define C0_SLPRQ 1
`define C0_SLPAK 2
`define C0_RST 8'h01

// receiver_flag_reg / receiver enable fields
`define F_WUP 7
`define F_RWRN 6
`define F_TWRN 5
`define F_RERR 4
`define F_TERR 3
`define F_BOFF 2
`define F_OVR 1
`define F_RXF 0

// acceptance_control_reg fields
`define AC_MODE_HI 5
`define AC_MODE_LO 4
`define MODE_32 2'h0
`define MODE_16 2'h1
`define MODE_8 2'h2
`define MODE_CLOSED 2'h3

// error counter limits, compared on 9 bits
`define WARN_LIMIT 9'h060
`define PASSIVE_LIMIT 9'h07F
`define BUS_DETACHED_STATE_LIMIT 9'h0FF

`define TXE_RST 3'h7
`define RECESSIVE 1'b1

`endif

// ===== core/can_acceptance_filter_irq.v
// can_acceptance_filter_irq: acceptance filter, flags, interrupt requests
// and configuration lock of the can controller, with an apb register slave.
// assumes the protocol engine on mclk_i gives identifier, frame and counters.
//
// The register offsets and the APB interface to the registers were decided locally.
`default_nettype none
`include "can_filt_map.vh"

// Function
// [R1] compare identifier bits against pattern, skip masked
// [R2] accepted frame sets receive full and hit
// [R3] lowest matching filter wins the hit field
// [R4] 32-bit mode: two filters, banks hit 0/1
// [R5] 16-bit mode: four filters, hits 0-1, 2-3
// [R6] 8-bit mode: eight filters, hits 0-3, 4-7
// [R7] closed mode never fills foreground, never flags
// [R8] transmit request while any buffer empty flagged
// [R9] receive full and interrupt right after frame end
// [R10] bus activity in sleep sets wake-up flag
// [R11] warning flags when error counters reach 96
// [R12] passive flags when error counters exceed 127
// [R13] bus-off flag when transmit counter exceeds 255
// [R14] eleven sources, four requests, each source enabled
// [R15] request holds while any enabled flag set
// [R16] flags clear only by writing one
// [R17] clear ignored while setting condition persists
// [R18] software must not clear flags by read-modify-write
// [R19] error counters have no write path
// [R20] config registers writable only under soft reset
// [R21] transmit pin recessive in any low-power mode
// [R22] both buffers full: discard frame, set overrun
// [R23] background copied to foreground only when empty
// [R24] hit field is binary filter index 0-7
// [R25] mask one is don't care, zero exact
module can_acceptance_filter_irq (
  input wire mclk_i,
  input wire arst_n_i,
  input wire psel_i,
  input wire penable_i,
  input wire pwrite_i,
  input wire [7:0] paddr_i,
  input wire [31:0] pwdata_i,
  output reg [31:0] prdata_o,
  output wire pready_o,
  output wire pslverr_o,
  input wire [31:0] rx_id_i,
  input wire rx_frame_ok_i,
  input wire [7:0] rx_err_cnt_i,
  input wire [8:0] tx_err_cnt_i,
  input wire [2:0] tx_done_i,
  input wire bus_idle_i,
  input wire power_down_i,
  input wire can_rx_i,
  input wire tx_bit_i,
  output reg can_tx_o,
  output reg rx_copy_o,
  output wire [2:0] tx_pending_o,
  output wire soft_reset_o,
  output wire sleep_o,
  output wire [7:0] module_control_1_o,
  output wire [7:0] bit_timing_0_o,
  output wire [7:0] bit_timing_1_o,
  output wire wakeup_irq_o,
  output wire error_irq_o,
  output wire rx_irq_o,
  output wire tx_irq_o
);

  localparam ST_RUN = 1'b0;
  localparam ST_SLEEP = 1'b1;
  // reset word of module_control_0, so the soft bit can be cut from it exactly
  localparam [7:0] C0_RST_V = `C0_RST;

  // one identifier byte against one pattern byte under its mask
  function match8;
    input [7:0] pat;
    input [7:0] msk;
    input [7:0] idb;
    begin
      match8 = &(~(pat ^ idb) | msk); // [R1] [R25]
    end
  endfunction

  // lowest set bit wins
  function [2:0] first_hit;
    input [7:0] h;
    integer k;
    begin
      first_hit = 3'h0;
      for (k = 7; k >= 0; k = k - 1) begin
        if (h[k]) begin
          first_hit = k[2:0]; // [R3] [R24]
        end
      end
    end
  endfunction

  // register state
  reg soft_q;
  reg slprq_q;
  reg state_q;
  reg [7:0] ctrl1_q;
  reg [7:0] bt0_q;
  reg [7:0] bt1_q;
  reg [1:0] mode_q;
  reg [2:0] hit_q;
  reg [7:0] rflg_q;
  reg [7:0] rier_q;
  reg [2:0] txe_q;
  reg [2:0] tier_q;
  reg bg_full_q;
  reg [2:0] bg_hit_q;
  reg rx_s1_q;
  reg rx_s2_q;
  reg wait_q;

  // apb decode
  wire access = psel_i & penable_i;
  wire done = access & wait_q;
  wire filt_adr = (paddr_i[7:6] == `FILT_PAGE) & (paddr_i[1:0] == 2'b00);
  reg known_adr;
  always @* begin
    case (paddr_i)
      `ADR_CTRL0, `ADR_CTRL1, `ADR_BT0, `ADR_BT1,
      `ADR_RFLG, `ADR_RIER, `ADR_TFLG, `ADR_TIER,
      `ADR_IDAC, `ADR_RXERR, `ADR_TXERR: known_adr = 1'b1;
      default: known_adr = filt_adr;
    endcase
  end
  // one wait state so the store's registered read is ready
  assign pready_o = done;
  assign pslverr_o = done & ~known_adr;
  wire wr = done & pwrite_i & known_adr;
  wire wr_cfg = wr & soft_q; // [R20]
  wire [7:0] wbyte = pwdata_i[7:0];

  // pattern and mask bytes
  wire [127:0] store;
  wire [7:0] store_rd;
  filt_store u_store (
    .mclk_i(mclk_i),
    .arst_n_i(arst_n_i),
    .we_i(wr_cfg & filt_adr), // [R20]
    .waddr_i(paddr_i[5:2]),
    .wdata_i(wbyte),
    .raddr_i(paddr_i[5:2]),
    .rdata_o(store_rd),
    .flat_o(store)
  );

  // per-byte comparators; bank byte k sees the id byte its mode assigns
  reg [7:0] bm;
  reg [7:0] idb;
  reg [7:0] hits;
  integer b;
  always @* begin
    bm = 8'h00;
    idb = 8'h00;
    for (b = 0; b < 8; b = b + 1) begin
      case (mode_q)
        `MODE_32: idb = rx_id_i[31-8*(b%4) -: 8];
        `MODE_16: idb = rx_id_i[31-8*(b%2) -: 8];
        default: idb = rx_id_i[31:24];
      endcase
      bm[b] = match8(store[8*b+7 -: 8], store[64+8*b+7 -: 8], idb); // [R1]
    end
    case (mode_q)
      `MODE_32: hits = {6'h00, &bm[7:4], &bm[3:0]}; // [R4]
      `MODE_16: hits = {4'h0, &bm[7:6], &bm[5:4], &bm[3:2], &bm[1:0]}; // [R5]
      `MODE_8: hits = bm; // [R6]
      default: hits = 8'h00; // [R7]
    endcase
  end

  wire sleeping = (state_q == ST_SLEEP);
  wire receive_full_flag = rflg_q[`F_RXF];
  wire accept = rx_frame_ok_i & (|hits); // [R7]
  wire [2:0] new_hit = first_hit(hits);
  // no copy while asleep; the pending copy runs after wake-up
  wire copy_bg = bg_full_q & ~receive_full_flag & ~sleeping; // [R23]
  wire direct = accept & ~copy_bg & ~receive_full_flag & ~bg_full_q;
  wire to_bg = accept & ~direct;
  wire ovr_set = to_bg & bg_full_q & ~copy_bg; // [R22]
  wire rxf_set = copy_bg | direct; // [R2] [R9]
  wire wake = sleeping & ~rx_s2_q; // [R10]

  // error conditions follow the engine's counters, read only here
  wire [8:0] rx_cnt = {1'b0, rx_err_cnt_i}; // [R19]
  wire rwrn_c = rx_cnt >= `WARN_LIMIT; // [R11]
  wire twrn_c = tx_err_cnt_i >= `WARN_LIMIT; // [R11]
  wire rerr_c = rx_cnt > `PASSIVE_LIMIT; // [R12]
  wire terr_c = tx_err_cnt_i > `PASSIVE_LIMIT; // [R12]
  // a 9-bit count can pass 255, so only exceeding the limit means bus off
  wire boff_c = tx_err_cnt_i > `BUS_DETACHED_STATE_LIMIT; // [R13]

  wire [7:0] rcond = {1'b0, rwrn_c, twrn_c, rerr_c, terr_c, boff_c, 2'b00};
  wire [7:0] rset = {wake, rwrn_c, twrn_c, rerr_c, terr_c, boff_c,
                     ovr_set, rxf_set};
  wire [7:0] rclr = (wr & (paddr_i == `ADR_RFLG)) ? wbyte : 8'h00; // [R16]
  // set wins over clear; a live condition blocks the clear
  wire [7:0] rflg_d = rset | (rflg_q & ~(rclr & ~rcond)); // [R16] [R17]
  wire [2:0] tclr = (wr & (paddr_i == `ADR_TFLG)) ? wbyte[2:0] : 3'h0;
  wire [2:0] txe_d = tx_done_i | (txe_q & ~tclr); // [R16]

  // receive staging and flags
  always @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rflg_q <= 8'h00;
      txe_q <= `TXE_RST;
      bg_full_q <= 1'b0;
      bg_hit_q <= 3'h0;
      hit_q <= 3'h0;
      rx_copy_o <= 1'b0;
    end else begin
      rflg_q <= rflg_d;
      txe_q <= txe_d;
      rx_copy_o <= rxf_set;
      if (copy_bg) begin
        hit_q <= bg_hit_q; // [R23]
      end else if (direct) begin
        hit_q <= new_hit; // [R2]
      end
      if (to_bg & (~bg_full_q | copy_bg)) begin
        bg_full_q <= 1'b1;
        bg_hit_q <= new_hit;
      end else if (copy_bg) begin
        bg_full_q <= 1'b0;
      end
    end
  end

  // can_rx_i comes from the pin, two flops before use
  always @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rx_s1_q <= `RECESSIVE;
      rx_s2_q <= `RECESSIVE;
    end else begin
      rx_s1_q <= can_rx_i;
      rx_s2_q <= rx_s1_q;
    end
  end

  // sleep handshake: enter once idle with all transmit buffers empty
  always @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_q <= ST_RUN;
    end else begin
      case (state_q)
        ST_RUN: begin
          if (slprq_q & ~soft_q & bus_idle_i & (&txe_q)) begin
            state_q <= ST_SLEEP;
          end
        end
        ST_SLEEP: begin
          if (wake | ~slprq_q | soft_q) begin
            state_q <= ST_RUN;
          end
        end
        default: state_q <= ST_RUN;
      endcase
    end
  end

  // control and configuration registers
  always @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      soft_q <= C0_RST_V[`C0_SOFT];
      slprq_q <= 1'b0;
      ctrl1_q <= 8'h00;
      bt0_q <= 8'h00;
      bt1_q <= 8'h00;
      mode_q <= `MODE_32;
      rier_q <= 8'h00;
      tier_q <= 3'h0;
    end else begin
      if (wr & (paddr_i == `ADR_CTRL0)) begin
        soft_q <= wbyte[`C0_SOFT];
        // the request may only be withdrawn once asleep
        if (wbyte[`C0_SLPRQ] | sleeping) begin
          slprq_q <= wbyte[`C0_SLPRQ];
        end
      end else if (wake) begin
        slprq_q <= 1'b0;
      end
      if (wr_cfg & (paddr_i == `ADR_CTRL1)) begin
        ctrl1_q <= wbyte; // [R20]
      end
      if (wr_cfg & (paddr_i == `ADR_BT0)) begin
        bt0_q <= wbyte; // [R20]
      end
      if (wr_cfg & (paddr_i == `ADR_BT1)) begin
        bt1_q <= wbyte; // [R20]
      end
      if (wr_cfg & (paddr_i == `ADR_IDAC)) begin
        mode_q <= wbyte[`AC_MODE_HI:`AC_MODE_LO]; // [R20]
      end
      if (wr & (paddr_i == `ADR_RIER)) begin
        rier_q <= wbyte;
      end
      if (wr & (paddr_i == `ADR_TIER)) begin
        tier_q <= wbyte[2:0];
      end
    end
  end

  // read mux; counters appear here and nowhere in the write path
  reg [7:0] rd_byte;
  always @* begin
    case (paddr_i)
      `ADR_CTRL0: rd_byte = {5'h00, sleeping, slprq_q, soft_q};
      `ADR_CTRL1: rd_byte = ctrl1_q;
      `ADR_BT0: rd_byte = bt0_q;
      `ADR_BT1: rd_byte = bt1_q;
      `ADR_RFLG: rd_byte = rflg_q;
      `ADR_RIER: rd_byte = rier_q;
      `ADR_TFLG: rd_byte = {5'h00, txe_q};
      `ADR_TIER: rd_byte = {5'h00, tier_q};
      `ADR_IDAC: rd_byte = {2'h0, mode_q, 1'b0, hit_q}; // [R24]
      `ADR_RXERR: rd_byte = rx_err_cnt_i; // [R19]
      `ADR_TXERR: rd_byte = tx_err_cnt_i[7:0]; // [R19]
      default: rd_byte = filt_adr ? store_rd : 8'h00;
    endcase
  end

  always @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      wait_q <= 1'b0;
      prdata_o <= 32'h0000_0000;
    end else begin
      wait_q <= access & ~wait_q;
      if (access & ~wait_q) begin
        prdata_o <= {24'h00_0000, rd_byte};
      end
    end
  end

  // transmit pin; registered so it never glitches on mode changes
  wire low_power = sleeping | soft_q | power_down_i;
  always @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      can_tx_o <= `RECESSIVE;
    end else begin
      can_tx_o <= low_power ? `RECESSIVE : tx_bit_i; // [R21]
    end
  end

  // four requests from eleven individually enabled sources
  assign wakeup_irq_o = rflg_q[`F_WUP] & rier_q[`F_WUP]; // [R14] [R15]
  assign error_irq_o = |(rflg_q[6:1] & rier_q[6:1]); // [R14] [R15]
  assign rx_irq_o = rflg_q[`F_RXF] & rier_q[`F_RXF]; // [R14] [R15]
  assign tx_irq_o = |(txe_q & tier_q); // [R8] [R15]

  assign tx_pending_o = ~txe_q;
  assign soft_reset_o = soft_q;
  assign sleep_o = sleeping;
  assign module_control_1_o = ctrl1_q;
  assign bit_timing_0_o = bt0_q;
  assign bit_timing_1_o = bt1_q;

endmodule

`default_nettype wire

// ===== core/filt_store.v
// filt_store: sixteen bytes of pattern and mask storage for the filter
// assumes one writer on mclk_i; read data are registered, flat view is live
`default_nettype none

module filt_store (
  input wire mclk_i,
  input wire arst_n_i,
  input wire we_i,
  input wire [3:0] waddr_i,
  input wire [7:0] wdata_i,
  input wire [3:0] raddr_i,
  output reg [7:0] rdata_o,
  output wire [127:0] flat_o
);

  reg [7:0] mem_q [0:15];
  integer i;

  always @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      for (i = 0; i < 16; i = i + 1) begin
        mem_q[i] <= 8'h00;
      end
      rdata_o <= 8'h00;
    end else begin
      if (we_i) begin
        mem_q[waddr_i] <= wdata_i;
      end
      rdata_o <= mem_q[raddr_i];
    end
  end

  // the comparators need every byte at once
  genvar g;
  generate
    for (g = 0; g < 16; g = g + 1) begin : flat_gen
      assign flat_o[8*g+7:8*g] = mem_q[g];
    end
  endgenerate

endmodule

`default_nettype wire

// ===== verif/can_acceptance_filter_irq_tb.sv
// can_acceptance_filter_irq_tb: filter table, then flag, lock and sleep cases
// assumes the design's apb slave, the node model and the bound checker
`default_nettype none
`include "can_filt_map.vh"
module can_acceptance_filter_irq_tb;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {logic [1:0] md; logic [63:0] p; logic [63:0] m; logic [31:0] id;
    logic [3:0] h;} row_t;
  logic mclk_i, arst_n_i, psel_i, penable_i, pwrite_i, power_down_i, pready_o, pslverr_o;
  logic can_rx_i, rx_frame_ok_i, tx_bit_i, can_tx_o, rx_copy_o, soft_reset_o, sleep_o, er;
  logic wakeup_irq_o, error_irq_o, rx_irq_o, tx_irq_o;
  logic [7:0] paddr_i, rx_err_cnt_i, bit_timing_0_o, bit_timing_1_o, module_control_1_o;
  logic [8:0] tx_err_cnt_i;
  logic [2:0] tx_done_i, tx_pending_o;
  logic [31:0] pwdata_i, prdata_o, rx_id_i, rd;
  int n_mismatch, n_compared, k;
  // hit 4'h8 means no filter may accept
  row_t rows [9] = '{
    '{`MODE_32, 64'h1234_5678_1234_5678, 64'h0, 32'h1234_5678, 4'h0},
    '{`MODE_32, 64'hAAAA_AAAA_1234_5678, 64'h0, 32'h1234_5678, 4'h1},
    '{`MODE_32, 64'h1234_5600_0000_0000, 64'h0000_00FF_0000_0000, 32'h1234_56AB, 4'h0},
    '{`MODE_32, 64'h0, 64'h0, 32'h0000_0001, 4'h8},
    '{`MODE_16, 64'h0000_0000_BEEF_0000, 64'h0, 32'hBEEF_1111, 4'h2},
    '{`MODE_8, 64'h0102_0304_0506_0708, 64'h0, 32'h07FF_FFFF, 4'h6},
    '{`MODE_8, 64'h0905_0905_0905_0905, 64'h0, 32'h0500_0000, 4'h1},
    '{`MODE_8, 64'h1111_1111_1111_1111, 64'h0000_00FF_0000_0000, 32'h7700_0000, 4'h3},
    '{`MODE_CLOSED, 64'h0, 64'hFFFF_FFFF_FFFF_FFFF, 32'h0, 4'h8}};
  can_acceptance_filter_irq can_acceptance_filter_irq_inst (.mclk_i, .arst_n_i, .psel_i,
    .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .rx_id_i,
    .rx_frame_ok_i, .rx_err_cnt_i, .tx_err_cnt_i, .tx_done_i, .bus_idle_i(1'b1),
    .power_down_i, .can_rx_i, .tx_bit_i, .can_tx_o, .rx_copy_o, .tx_pending_o, .soft_reset_o,
    .sleep_o, .module_control_1_o, .bit_timing_0_o, .bit_timing_1_o, .wakeup_irq_o,
    .error_irq_o, .rx_irq_o, .tx_irq_o);
  can_node_model node (.mclk_i, .rx_id_o(rx_id_i), .rx_frame_ok_o(rx_frame_ok_i),
    .can_rx_o(can_rx_i), .rx_err_cnt_o(rx_err_cnt_i), .tx_err_cnt_o(tx_err_cnt_i),
    .tx_done_o(tx_done_i), .tx_bit_o(tx_bit_i));
  initial begin
    mclk_i = 1'b0;
    forever #50 mclk_i = ~mclk_i;
  end
  task automatic check(input string nm, input logic [31:0] s, input logic [31:0] e);
    n_compared++;
    if (s !== e) begin
      n_mismatch++;
      $display("unexpected %s: expected %h seen %h", nm, e, s);
    end
  endtask
  task report_and_stop();
    if (n_mismatch == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int t;
    psel_i <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge mclk_i);
    penable_i <= 1'b1;
    // sampled at the closing edge, before that edge's updates land
    for (t = 0; t < 20; t++) begin
      @(posedge mclk_i);
      if (pready_o === 1'b1) break;
    end
    if (t == 20) begin
      check("pready wait", 32'h0, 32'h1);
      report_and_stop();
    end
    rd = prdata_o;
    er = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    @(posedge mclk_i);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    check(nm, rd, e);
  endtask
  task automatic wait_sleep(input logic v);
    int t;
    for (t = 0; t < 50; t++) begin
      @(negedge mclk_i);
      if (sleep_o === v) break;
    end
    if (t == 50) begin
      check("sleep wait", 32'h0, 32'h1);
      report_and_stop();
    end
    @(posedge mclk_i);
  endtask
  initial begin
    arst_n_i = 1'b0;
    psel_i = 1'b0;
    penable_i = 1'b0;
    pwrite_i = 1'b0;
    paddr_i = 8'h00;
    pwdata_i = 32'h0;
    power_down_i = 1'b0;
    repeat (8) @(posedge mclk_i);
    arst_n_i <= 1'b1;
    check("soft reset", 32'(soft_reset_o), 32'h1);
    rchk("ctrl0", `ADR_CTRL0, 32'h0000_0001);
    rchk("tx flags", `ADR_TFLG, 32'h0000_0007);
    apb(1'b0, 8'h3C, 32'h0);
    check("unmapped", 32'(er), 32'h1);
    wr(`ADR_RIER, 32'h0000_00FF);
    foreach (rows[r]) begin
      wr(`ADR_CTRL0, 32'h0000_0001);
      wr(`ADR_IDAC, {26'h0, rows[r].md, 4'h0});
      for (k = 0; k < 8; k++) begin
        wr(8'h40 + 8'(4 * k), {24'h0, rows[r].p[63 - 8 * k -: 8]});
        wr(8'h60 + 8'(4 * k), {24'h0, rows[r].m[63 - 8 * k -: 8]});
      end
      wr(`ADR_CTRL0, 32'h0000_0000);
      node.frame(rows[r].id);
      @(negedge mclk_i);
      check("load strobe", 32'(rx_copy_o), 32'(rows[r].h < 4'h8));
      check("rx request", 32'(rx_irq_o), 32'(rows[r].h < 4'h8));
      @(posedge mclk_i);
      rchk("receive full", `ADR_RFLG, 32'(rows[r].h < 4'h8));
      if (rows[r].h < 4'h8)
        rchk("hit", `ADR_IDAC, {26'h0, rows[r].md, 1'b0, rows[r].h[2:0]});
      wr(`ADR_RFLG, 32'h0000_0001);
    end
    wr(`ADR_CTRL0, 32'h0000_0001);
    wr(`ADR_BT0, 32'h0000_005A);
    wr(`ADR_BT1, 32'h0000_00C3);
    wr(`ADR_CTRL1, 32'h0000_003C);
    wr(`ADR_CTRL0, 32'h0000_0000);
    wr(`ADR_BT0, 32'h0000_00A5);
    wr(`ADR_BT1, 32'h0000_0011);
    wr(`ADR_CTRL1, 32'h0000_0022);
    check("timing", 32'(bit_timing_0_o), 32'h0000_005A);
    check("timing 1", 32'(bit_timing_1_o), 32'h0000_00C3);
    check("control 1", 32'(module_control_1_o), 32'h0000_003C);
    // mask byte 0 still holds the closed-mode row's value
    wr(8'h60, 32'h0000_0000);
    rchk("locked mask", 8'h60, 32'h0000_00FF);
    wr(`ADR_RXERR, 32'h0000_00FF);
    rchk("rx counter", `ADR_RXERR, 32'h0);
    node.levels(8'h60, 9'h080);
    wr(`ADR_RFLG, 32'h0000_0040);
    rchk("warn flags", `ADR_RFLG, 32'h0000_0068);
    check("error request", 32'(error_irq_o), 32'h1);
    node.levels(8'h80, 9'h100);
    wr(`ADR_RFLG, 32'h0000_0000);
    rchk("passive flags", `ADR_RFLG, 32'h0000_007C);
    node.levels(8'h00, 9'h000);
    wr(`ADR_RFLG, 32'h0000_007C);
    rchk("flags cleared", `ADR_RFLG, 32'h0);
    check("error idle", 32'(error_irq_o), 32'h0);
    // closed mode is left with every mask bit don't care, so any id hits
    wr(`ADR_CTRL0, 32'h0000_0001);
    wr(`ADR_IDAC, 32'h0);
    wr(`ADR_CTRL0, 32'h0000_0000);
    for (k = 0; k < 3; k++) node.frame(32'(k));
    rchk("overrun", `ADR_RFLG, 32'h0000_0003);
    check("overrun request", 32'(error_irq_o), 32'h1);
    wr(`ADR_RFLG, 32'h0000_0001);
    rchk("background copy", `ADR_RFLG, 32'h0000_0003);
    wr(`ADR_RFLG, 32'h0000_0003);
    rchk("no stale copy", `ADR_RFLG, 32'h0);
    wr(`ADR_TIER, 32'h0000_0007);
    check("tx request", 32'(tx_irq_o), 32'h1);
    wr(`ADR_TFLG, 32'h0000_0003);
    check("pending", 32'(tx_pending_o), 32'h3);
    check("tx one empty", 32'(tx_irq_o), 32'h1);
    wr(`ADR_TFLG, 32'h0000_0004);
    check("tx none empty", 32'(tx_irq_o), 32'h0);
    node.done(3'h2);
    @(negedge mclk_i);
    check("done pending", 32'(tx_pending_o), 32'h5);
    check("tx done request", 32'(tx_irq_o), 32'h1);
    @(posedge mclk_i);
    wr(`ADR_TIER, 32'h0000_0005);
    check("tx masked", 32'(tx_irq_o), 32'h0);
    node.done(3'h5);
    wr(`ADR_CTRL0, 32'h0000_0002);
    wait_sleep(1'b1);
    node.wake();
    wait_sleep(1'b0);
    rchk("wakeup flag", `ADR_RFLG, 32'h0000_0080);
    check("wakeup request", 32'(wakeup_irq_o), 32'h1);
    power_down_i <= 1'b1;
    repeat (3) @(posedge mclk_i);
    power_down_i <= 1'b0;
    repeat (2) @(posedge mclk_i);
    // second reset in mid-run, with the wakeup flag still set
    arst_n_i <= 1'b0;
    @(posedge mclk_i);
    check("reset pin", 32'(can_tx_o), 32'h1);
    check("reset soft", 32'(soft_reset_o), 32'h1);
    check("reset pending", 32'(tx_pending_o), 32'h0);
    check("reset wakeup", 32'(wakeup_irq_o), 32'h0);
    arst_n_i <= 1'b1;
    rchk("reset flags", `ADR_RFLG, 32'h0);
    report_and_stop();
  end
endmodule
bind can_acceptance_filter_irq can_filt_checker can_filt_checker_inst (.mclk_i, .arst_n_i,
  .psel_i, .penable_i, .pready_o, .pslverr_o, .power_down_i, .tx_bit_i, .can_tx_o,
  .soft_reset_o, .sleep_o, .rx_copy_o, .tx_pending_o, .tx_irq_o, .tx_done_i, .can_rx_i);
`default_nettype wire

// ===== verif/can_filt_checker.sv
// can_filt_checker: port-level properties of the filter and flag block
// assumes binding to can_acceptance_filter_irq, one clock, async reset
`default_nettype none
module can_filt_checker (
  input wire logic mclk_i,
  input wire logic arst_n_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pready_o,
  input wire logic pslverr_o,
  input wire logic power_down_i,
  input wire logic tx_bit_i,
  input wire logic can_tx_o,
  input wire logic soft_reset_o,
  input wire logic sleep_o,
  input wire logic rx_copy_o,
  input wire logic [2:0] tx_pending_o,
  input wire logic tx_irq_o,
  input wire logic [2:0] tx_done_i,
  input wire logic can_rx_i
);
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!arst_n_i);
  sequence setup_s;
    psel_i && !penable_i;
  endsequence
  sequence wait_then_ready_s;
    (psel_i && penable_i && !pready_o) ##1 (psel_i && penable_i && pready_o);
  endsequence
  a_apb_one_wait: assert property (setup_s |=> wait_then_ready_s)
    else $error("apb access without exactly one wait state");
  a_ready_in_access: assert property (pready_o |-> psel_i && penable_i && $past(penable_i))
    else $error("pready outside second access cycle");
  a_err_with_ready: assert property (pslverr_o |-> pready_o)
    else $error("pslverr without pready");
  a_tx_recess_power: assert property (power_down_i |=> can_tx_o)
    else $error("transmit pin dominant in power down");
  a_tx_recess_mode: assert property (
    (sleep_o && $past(sleep_o)) || (soft_reset_o && $past(soft_reset_o)) |-> can_tx_o)
    else $error("transmit pin dominant in sleep or soft reset");
  // two normal cycles, so a mode change at the edge cannot excuse a slip
  a_tx_follows_bit: assert property (
    (!(power_down_i || soft_reset_o || sleep_o)) [*2] |-> can_tx_o == $past(tx_bit_i))
    else $error("transmit pin not one cycle behind engine bit");
  a_copy_one_cycle: assert property (rx_copy_o |=> !rx_copy_o)
    else $error("foreground load strobe longer than one cycle");
  a_tx_irq_empty: assert property (tx_irq_o |-> tx_pending_o != 3'h7)
    else $error("transmit request with every buffer scheduled");
  a_done_sets_empty: assert property (
    tx_done_i != 3'h0 |=> (tx_pending_o & $past(tx_done_i)) == 3'h0)
    else $error("finished buffer still pending");
  a_wake_on_activity: assert property (sleep_o && $fell(can_rx_i) |-> ##[1:4] !sleep_o)
    else $error("sleep not left after bus activity");
endmodule
`default_nettype wire

// ===== verif/can_node_model.sv
// can_node_model: far side of the block, a bus node seen through its engine
// assumes its tasks are called just after a rising edge of mclk_i
`default_nettype none
module can_node_model (
  input wire logic mclk_i,
  output logic [31:0] rx_id_o,
  output logic rx_frame_ok_o,
  output logic can_rx_o,
  output logic [7:0] rx_err_cnt_o,
  output logic [8:0] tx_err_cnt_o,
  output logic [2:0] tx_done_o,
  output logic tx_bit_o
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    rx_id_o = 32'h0;
    rx_frame_ok_o = 1'b0;
    can_rx_o = 1'b1;
    rx_err_cnt_o = 8'h00;
    tx_err_cnt_o = 9'h000;
    tx_done_o = 3'h0;
    tx_bit_o = 1'b0;
  end
  always @(posedge mclk_i) tx_bit_o <= ~tx_bit_o;
  // identifier is inverted outside a frame so stale bits cannot match
  task automatic frame(input logic [31:0] id);
    @(posedge mclk_i);
    rx_frame_ok_o <= 1'b1;
    rx_id_o <= id;
    @(posedge mclk_i);
    rx_frame_ok_o <= 1'b0;
    rx_id_o <= ~id;
  endtask
  task automatic levels(input logic [7:0] r, input logic [8:0] t);
    @(posedge mclk_i);
    rx_err_cnt_o <= r;
    tx_err_cnt_o <= t;
  endtask
  task automatic done(input logic [2:0] m);
    @(posedge mclk_i);
    tx_done_o <= m;
    @(posedge mclk_i);
    tx_done_o <= 3'h0;
  endtask
  task automatic wake();
    @(posedge mclk_i);
    can_rx_o <= 1'b0;
    repeat (6) @(posedge mclk_i);
    can_rx_o <= 1'b1;
  endtask
endmodule
`default_nettype wire
